// File: design/pmtb_pkg.sv
// Package: register map, field layout, reset values and carriers of the master time base
package pmtb_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFS_PERIOD   = 8'h00;
  localparam logic [7:0] OFS_COMPARE  = 8'h04;
  localparam logic [7:0] OFS_CONTROL  = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_RUN      = 8'h14;
  localparam logic [7:0] OFS_COUNTER  = 8'h18;

  // Values after reset
  localparam logic [15:0] RST_PERIOD  = 16'hFFF8;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [2:0]  RST_IRQ     = 3'h0;

  // Field positions
  localparam int CMP_LSB       = 3;  // Compare count starts here
  localparam int CTRL_PEND_BIT = 12; // Special event pending, hardware owned
  localparam int RUN_EN_BIT    = 0;  // Module enable in run register

  // Interrupt status bit positions
  localparam int IRQ_TRIG  = 0;
  localparam int IRQ_BOUND = 1;
  localparam int IRQ_SYNC  = 2;
  localparam int IRQ_W     = 3;

  // Timing figures of the counter step and the compare resolution
  localparam int STEP_PS = 1040;
  localparam int RES_PS  = 8320;

  // Control register layout
  typedef struct packed {
    logic [2:0] unused;
    logic       eventIrqPending;
    logic       eventIrqEnable;
    logic       immediatePeriodUpdate;
    logic       syncPolarityInvert;
    logic       syncOutputEnable;
    logic       externalSyncEnable;
    logic [2:0] syncSourceSelect;
    logic [3:0] eventPostscaleSelect;
  } pmtb_ctrl_t;

  // Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } pmtb_wbreq_t;

endpackage

// File: design/pmtb_top.sv
// Master time base: period, special event compare, secondary control, Wishbone slave
// Function
// - Full 16-bit read/write period value for the primary time base.
// - 13-bit compare count in bits 15..3; a match produces the special event.
// - Compare register bits 2..0 are not implemented and read zero.
// - One count step per clock; compare resolves to eight steps.
// - Control bit 8 enables the synchronization output.
// - Hardware pending flag shows a pending special event interrupt; not writable.
// - Interrupt enable bit allows or blocks the special event interrupt.
// - Immediate update loads period at once, else at the cycle boundary or whenever the module is disabled.
// - Four-bit postscaler emits one trigger per eventPostscaleSelect+1 compare matches.
module pmtb_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [3:0]  wbSel,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  // Synchronization pins
  input  wire logic        syncIn,
  output logic             syncOut,
  // Event outputs
  output logic             eventTrig,
  output logic             irq
);

  // Elaboration check: registers, counter and compare grid are fixed at 16 bits
  if (CNT_W != 16) begin : gWidthCheck
    $error("pmtb_top: CNT_W must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  pmtb_pkg::pmtb_wbreq_t req;
  logic                  ack_ff;
  logic                  wrStrobe;
  logic [15:0]           wrMask;

  assign req      = '{wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI};
  // Write lands on the edge where the master sees ack
  assign wrStrobe = req.cyc && req.stb && req.we && ack_ff;
  assign wrMask   = {{8{req.sel[1]}}, {8{req.sel[0]}}};

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ack_ff <= 1'b0;
    else        ack_ff <= req.cyc && req.stb && !ack_ff;
  end
  assign wbAck = ack_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [15:0]            periodBuf_ff;
  logic [15:0]            compare_ff;
  pmtb_pkg::pmtb_ctrl_t   ctrl_ff;
  logic [2:0]             irqMask_ff;
  logic                   enable_ff;
  logic [15:0]            ctrlNew;

  assign ctrlNew = (ctrl_ff & ~wrMask) | (req.dat[15:0] & wrMask);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periodBuf_ff <= pmtb_pkg::RST_PERIOD;
      compare_ff   <= pmtb_pkg::RST_COMPARE;
      ctrl_ff      <= pmtb_pkg::RST_CONTROL;
      irqMask_ff   <= pmtb_pkg::RST_IRQ;
      enable_ff    <= 1'b0;
    end else if (wrStrobe) begin
      case (req.adr)
        pmtb_pkg::OFS_PERIOD:
          periodBuf_ff <= (periodBuf_ff & ~wrMask) | (req.dat[15:0] & wrMask);
        pmtb_pkg::OFS_COMPARE:
          compare_ff <= ((compare_ff & ~wrMask) | (req.dat[15:0] & wrMask))
                        & 16'hFFF8;
        pmtb_pkg::OFS_CONTROL: begin
          ctrl_ff                 <= ctrlNew;
          ctrl_ff.unused          <= 3'b000;
          ctrl_ff.eventIrqPending <= 1'b0;
        end
        pmtb_pkg::OFS_IRQ_MASK:
          if (req.sel[0]) irqMask_ff <= req.dat[2:0];
        pmtb_pkg::OFS_RUN:
          if (req.sel[0]) enable_ff <= req.dat[pmtb_pkg::RUN_EN_BIT];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary master counter and active period
  logic [15:0] count_ff;
  logic [15:0] periodAct_ff;
  logic        syncPrev_ff;
  logic        syncActive;
  logic        syncEdge;
  logic        boundary;
  logic        periodWrite;

  // Polarity folds the input to an active-high view
  assign syncActive  = syncIn ^ ctrl_ff.syncPolarityInvert;
  assign syncEdge    = syncActive && !syncPrev_ff && ctrl_ff.externalSyncEnable;
  assign boundary    = enable_ff && (count_ff >= periodAct_ff);
  assign periodWrite = wrStrobe && req.adr == pmtb_pkg::OFS_PERIOD;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) syncPrev_ff <= 1'b0;
    else        syncPrev_ff <= syncActive;
  end

  // One count per clock; >= keeps a lowered period from running away
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)                    count_ff <= 16'h0000;
    else if (!enable_ff)           count_ff <= 16'h0000;
    else if (syncEdge || boundary) count_ff <= 16'h0000;
    else                           count_ff <= count_ff + 16'h0001;
  end

  // Active period: immediate load, else held until the boundary; follows the buffer while disabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      periodAct_ff <= pmtb_pkg::RST_PERIOD;
    else if (periodWrite && ctrl_ff.immediatePeriodUpdate)
      periodAct_ff <= (periodBuf_ff & ~wrMask) | (req.dat[15:0] & wrMask);
    else if (boundary || !enable_ff)
      periodAct_ff <= periodBuf_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare match and postscaler
  logic       cmpMatch;
  logic [3:0] psCount_ff;
  logic       trig_ff;

  // Low bits of the compare are zero, so matches fall on multiples of eight
  assign cmpMatch = enable_ff && (count_ff == compare_ff);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      psCount_ff <= 4'h0;
      trig_ff    <= 1'b0;
    end else begin
      trig_ff <= 1'b0;
      if (!enable_ff) begin
        psCount_ff <= 4'h0;
      end else if (cmpMatch) begin
        if (psCount_ff >= ctrl_ff.eventPostscaleSelect) begin
          psCount_ff <= 4'h0;
          trig_ff    <= 1'b1;
        end else begin
          psCount_ff <= psCount_ff + 4'h1;
        end
      end
    end
  end
  assign eventTrig = trig_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sync output: pulse on boundary, rests at inactive level
  logic syncOut_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) syncOut_ff <= 1'b0;
    else syncOut_ff <= ctrl_ff.syncPolarityInvert
                       ^ (ctrl_ff.syncOutputEnable && boundary);
  end
  assign syncOut = syncOut_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write one to clear, set wins
  logic [2:0] irqStat_ff;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic [2:0] irqGate;

  assign irqSet  = {syncEdge, boundary, trig_ff};
  assign irqClr  = (wrStrobe && req.adr == pmtb_pkg::OFS_IRQ_STAT && req.sel[0])
                   ? req.dat[2:0] : 3'b000;
  assign irqGate = {2'b11, ctrl_ff.eventIrqEnable};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irqStat_ff <= pmtb_pkg::RST_IRQ;
    else        irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
  end

  // The special event also needs its own enable to reach the line
  assign irq = |(irqStat_ff & irqMask_ff & irqGate);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered so it is stable while ack is high
  logic [31:0] nxt_rdData;
  logic [31:0] rdData_ff;
  logic [15:0] ctrlView;

  always_comb begin
    ctrlView                          = ctrl_ff;
    ctrlView[pmtb_pkg::CTRL_PEND_BIT] = irqStat_ff[pmtb_pkg::IRQ_TRIG];
  end

  always_comb begin
    case (req.adr)
      pmtb_pkg::OFS_PERIOD:   nxt_rdData = {16'h0000, periodBuf_ff};
      pmtb_pkg::OFS_COMPARE:  nxt_rdData = {16'h0000, compare_ff[15:3], 3'b000};
      pmtb_pkg::OFS_CONTROL:  nxt_rdData = {16'h0000, ctrlView};
      pmtb_pkg::OFS_IRQ_STAT: nxt_rdData = {29'h0000_0000, irqStat_ff};
      pmtb_pkg::OFS_IRQ_MASK: nxt_rdData = {29'h0000_0000, irqMask_ff};
      pmtb_pkg::OFS_RUN:      nxt_rdData = {31'h0000_0000, enable_ff};
      pmtb_pkg::OFS_COUNTER:  nxt_rdData = {16'h0000, count_ff};
      default:                nxt_rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)                              rdData_ff <= 32'h0000_0000;
    else if (req.cyc && req.stb && !ack_ff)  rdData_ff <= nxt_rdData;
  end
  assign wbDatO = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_period_store: assert property (
    periodWrite && req.sel[1:0] == 2'b11 |=> periodBuf_ff == $past(req.dat[15:0]))
    else $error("period register did not take the written value");

  chk_compare_store: assert property (
    wrStrobe && req.adr == pmtb_pkg::OFS_COMPARE && req.sel[1:0] == 2'b11
    |=> compare_ff[15:3] == $past(req.dat[15:3]))
    else $error("compare count did not take the written value");

  chk_compare_lowbits: assert property (
    ack_ff && req.adr == pmtb_pkg::OFS_COMPARE |-> wbDatO[2:0] == 3'b000)
    else $error("compare low bits read nonzero");

  chk_match_grid: assert property (
    cmpMatch |-> count_ff[2:0] == 3'b000 ##1 count_ff != $past(count_ff))
    else $error("compare match off the eight-step grid");

  chk_syncout_off: assert property (
    !ctrl_ff.syncOutputEnable |=> syncOut == $past(ctrl_ff.syncPolarityInvert))
    else $error("sync output moved while disabled");

  chk_pending_view: assert property (
    trig_ff ##1 (ack_ff && req.adr == pmtb_pkg::OFS_CONTROL && !req.we
    && $past(irqStat_ff[0])) |-> wbDatO[12])
    else $error("pending flag not shown after trigger");

  chk_irq_gate: assert property (
    !ctrl_ff.eventIrqEnable && (irqStat_ff[2:1] & irqMask_ff[2:1]) == 2'b00 |-> !irq)
    else $error("interrupt raised while special event disabled");

  chk_period_immed: assert property (
    periodWrite && ctrl_ff.immediatePeriodUpdate && req.sel[1:0] == 2'b11
    |=> periodAct_ff == $past(req.dat[15:0]))
    else $error("immediate period update did not apply");

  chk_period_defer: assert property (
    enable_ff && !boundary && !(periodWrite && ctrl_ff.immediatePeriodUpdate)
    |=> $stable(periodAct_ff))
    else $error("period changed away from a boundary");

  chk_postscale_hit: assert property (
    cmpMatch && psCount_ff == ctrl_ff.eventPostscaleSelect |=> trig_ff)
    else $error("postscaler missed its trigger");

  chk_postscale_skip: assert property (
    !cmpMatch |=> !trig_ff)
    else $error("trigger without a compare match");

  chk_syncout_pol: assert property (
    boundary && ctrl_ff.syncOutputEnable |=> syncOut != $past(ctrl_ff.syncPolarityInvert))
    else $error("sync output pulse at wrong level");

  // Active sync edge, folded by polarity, restarts the count and flags status
  chk_sync_restart: assert property (
    ctrl_ff.externalSyncEnable && $changed(syncIn) && $stable(ctrl_ff.syncPolarityInvert)
    && syncIn != ctrl_ff.syncPolarityInvert
    |=> count_ff == 16'h0000 && irqStat_ff[pmtb_pkg::IRQ_SYNC])
    else $error("sync input edge did not restart the time base");

  // Set wins over a write-one clear landing in the same cycle
  chk_pending_set: assert property (
    trig_ff |=> irqStat_ff[pmtb_pkg::IRQ_TRIG])
    else $error("special event trigger did not set its status");

  chk_irq_raise: assert property (
    irqStat_ff[pmtb_pkg::IRQ_TRIG] && irqMask_ff[pmtb_pkg::IRQ_TRIG]
    && ctrl_ff.eventIrqEnable |-> irq)
    else $error("enabled special event did not raise the interrupt");

  chk_boundary_wrap: assert property (
    boundary |=> count_ff == 16'h0000)
    else $error("counter did not wrap at the period boundary");

  cov_trigger:   cover property (trig_ff && ctrl_ff.eventPostscaleSelect != 4'h0);
  cov_boundary:  cover property (boundary && !ctrl_ff.immediatePeriodUpdate);
  cov_ext_sync:  cover property (syncEdge && ctrl_ff.syncPolarityInvert);
  cov_irq:       cover property (irq && irqStat_ff[0]);

endmodule

// File: testbench/pmtb_bench.sv
// Self-checking bench of the master time base: registers, triggers, sync output, interrupt
module pmtb_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Compare two values, count the check and report a mismatch at once
  `define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

  ////////////////////////////////////////////////////////////////////////////
  // Design under test and stimulus signals
  logic        clock;
  logic        rst_n;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [3:0]  wbSel;
  logic [7:0]  wbAdr;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        syncIn;
  logic        syncOut;
  logic        eventTrig;
  logic        irq;
  int          fails;
  int          totalChecks;
  int          trigCnt;
  int          actCnt;
  logic [31:0] rdData;
  // Per run: compare value, control word, expected triggers and sync-active cycles
  logic [15:0] cfgCmp  [4] = '{16'h0008, 16'h0008, 16'h0008, 16'h0018};
  logic [15:0] cfgCtrl [4] = '{16'h0500, 16'h0001, 16'h030F, 16'h0200};
  int          cfgTrig [4] = '{32, 16, 2, 0};
  int          cfgAct  [4] = '{32, 0, 32, 0};

  pmtb_top pmtb_top_inst (
    .clock     (clock),
    .rst_n     (rst_n),
    .wbCyc     (wbCyc),
    .wbStb     (wbStb),
    .wbWe      (wbWe),
    .wbSel     (wbSel),
    .wbAdr     (wbAdr),
    .wbDatI    (wbDatI),
    .wbDatO    (wbDatO),
    .wbAck     (wbAck),
    .syncIn    (syncIn),
    .syncOut   (syncOut),
    .eventTrig (eventTrig),
    .irq       (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Classic single Wishbone cycle; holds the request until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         output logic [31:0] rd);
    @(posedge clock);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= dat;
    wbSel  <= 4'hF;
    // No assumed latency: only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    logic [31:0] x;
    wb_xfer(1'b1, adr, {16'h0000, d}, x);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] x;
    wb_xfer(1'b0, adr, 32'h0000_0000, x);
    `CHK(x, e)
  endtask

  // Interrupt level is combinational of registers, so look after the edge settles
  task automatic irqchk(input logic e);
    @(negedge clock);
    `CHK(irq, e)
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs about 2900 cycles
  initial begin
    repeat (10000) @(posedge clock);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  // Main sequence
  initial begin
    fails = 0;
    totalChecks = 0;
    rst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'h0;
    wbAdr = 8'h00;
    wbDatI = 32'h0000_0000;
    syncIn = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values and access kinds
    rdchk(pmtb_pkg::OFS_PERIOD, 32'h0000_FFF8);
    rdchk(pmtb_pkg::OFS_COMPARE, 32'h0000_0000);
    rdchk(pmtb_pkg::OFS_CONTROL, 32'h0000_0000);
    wr(pmtb_pkg::OFS_PERIOD, 16'hA5C3);
    rdchk(pmtb_pkg::OFS_PERIOD, 32'h0000_A5C3);
    wr(pmtb_pkg::OFS_COMPARE, 16'hFFFF);
    rdchk(pmtb_pkg::OFS_COMPARE, 32'h0000_FFF8);
    wr(pmtb_pkg::OFS_CONTROL, 16'hFFFF);
    rdchk(pmtb_pkg::OFS_CONTROL, 32'h0000_0FFF);
    rdchk(8'h1C, 32'h0000_0000);
    // Shortest legal period, low bits zero
    wr(pmtb_pkg::OFS_PERIOD, 16'h0010);
    // Postscaler codes, sync output enable and polarity; 544 cycles = 32 periods
    for (int i = 0; i < 4; i++) begin
      wr(pmtb_pkg::OFS_RUN, 16'h0000);
      wr(pmtb_pkg::OFS_COMPARE, cfgCmp[i]);
      wr(pmtb_pkg::OFS_CONTROL, cfgCtrl[i]);
      wr(pmtb_pkg::OFS_RUN, 16'h0001);
      repeat (20) @(posedge clock);
      trigCnt = 0;
      actCnt = 0;
      repeat (544) begin
        @(negedge clock);
        trigCnt += (eventTrig === 1'b1);
        actCnt += (syncOut === ~cfgCtrl[i][9]);
      end
      `CHK(trigCnt, cfgTrig[i])
      `CHK(actCnt, cfgAct[i])
    end
    // Period shortened mid-count: immediate wraps at once, deferred keeps counting
    for (int m = 0; m < 2; m++) begin
      wr(pmtb_pkg::OFS_RUN, 16'h0000);
      wr(pmtb_pkg::OFS_CONTROL, (m == 1) ? 16'h0400 : 16'h0000);
      wr(pmtb_pkg::OFS_PERIOD, 16'hFFF8);
      wr(pmtb_pkg::OFS_RUN, 16'h0001);
      repeat (100) @(posedge clock);
      wr(pmtb_pkg::OFS_PERIOD, 16'h0010);
      wb_xfer(1'b0, pmtb_pkg::OFS_COUNTER, 32'h0000_0000, rdData);
      `CHK(rdData[15:0] > 16'h0010, m == 0)
    end
    wr(pmtb_pkg::OFS_RUN, 16'h0000);
    // Interrupt: pending flag, enable gating, mask and clear
    wb_xfer(1'b0, pmtb_pkg::OFS_IRQ_STAT, 32'h0000_0000, rdData);
    `CHK(rdData[1:0], 2'b11)
    wr(pmtb_pkg::OFS_IRQ_MASK, 16'h0001);
    wr(pmtb_pkg::OFS_CONTROL, 16'h0000);
    irqchk(1'b0);
    wr(pmtb_pkg::OFS_CONTROL, 16'h0800);
    irqchk(1'b1);
    rdchk(pmtb_pkg::OFS_CONTROL, 32'h0000_1800);
    wr(pmtb_pkg::OFS_IRQ_MASK, 16'h0000);
    irqchk(1'b0);
    wr(pmtb_pkg::OFS_IRQ_MASK, 16'h0001);
    wr(pmtb_pkg::OFS_IRQ_STAT, 16'h0007);
    irqchk(1'b0);
    wr(pmtb_pkg::OFS_CONTROL, 16'h1800);
    rdchk(pmtb_pkg::OFS_CONTROL, 32'h0000_0800);
    // External sync at either polarity: the active edge restarts the count, sets status bit 2
    for (int p = 0; p < 2; p++) begin
      wr(pmtb_pkg::OFS_RUN, 16'h0000);
      syncIn <= (p == 1);
      wr(pmtb_pkg::OFS_CONTROL, (p == 1) ? 16'h0280 : 16'h0080);
      wr(pmtb_pkg::OFS_PERIOD, 16'hFFF8);
      wr(pmtb_pkg::OFS_IRQ_STAT, 16'h0007);
      wr(pmtb_pkg::OFS_RUN, 16'h0001);
      repeat (100) @(posedge clock);
      syncIn <= (p == 0);
      wb_xfer(1'b0, pmtb_pkg::OFS_COUNTER, 32'h0000_0000, rdData);
      `CHK(rdData[15:0] < 16'h0010, 1'b1)
      wb_xfer(1'b0, pmtb_pkg::OFS_IRQ_STAT, 32'h0000_0000, rdData);
      `CHK(rdData[pmtb_pkg::IRQ_SYNC], 1'b1)
    end
    print_verdict();
  end

endmodule
